// >>> verilog/sleep_pkg.sv
// Function
// - code 010 enters power-down; main oscillator stops, external irqs, address watch, watchdog run.
// - power-down wakes only on resets, address match, level irq 0/1, or irq line 2.
// - power-down halts every generated clock; only asynchronous modules operate.
// - leaving power-down waits a start-up delay set by the clock source fuses.
// - code 011 enters power-save; like power-down but async slow timer keeps running.
// - slow timer events wake power-save only with timer enable and global enable set.
// - slow timer not async clocked makes its contents undefined after power-save.
// - power-save stops all clocks except the slow timer clock.
// - code 110 with crystal enters standby; oscillator runs, wake-up takes six cycles.
// - code 111 with crystal enters extended standby; oscillator runs, six-cycle wake-up.
// - mode field at control bits 7,5,4; codes 100 and 101 reserved.
// - enabled ADC stays enabled in sleep; re-enable makes next conversion extended.
// - comparator auto-disabled beyond idle and noise reduction; its reference use persists.
// - fuse-enabled brown-out detector stays active in every sleep mode.
// - voltage reference on only when brown-out, comparator or ADC needs it.
// - an enabled watchdog keeps running in every sleep mode.
// - input buffers off when io and ADC clocks both stop, except wake inputs.
// - debug fuse on keeps the main clock source running in power-down and power-save.
// - test-port off bit or unprogrammed fuse disables test port; idle data-out floats.
// - sleep entered only when sleep-enable bit 6 is one.
// - code 000 selects idle, halting cpu and flash clocks only.
// - code 001 selects noise reduction, halting io, cpu and flash clocks.
// - interrupt wake holds the cpu four cycles beyond start-up, then resumes.
package sleep_pkg;
    localparam logic [3:0] adr_control = 4'h0;
    localparam logic [3:0] adr_status = 4'h4;
    localparam logic [3:0] adr_misc = 4'h8;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] misc_reset = 8'h00;
    localparam int bit_sm2 = 7;
    localparam int bit_se = 6;
    localparam int bit_sm1 = 5;
    localparam int bit_sm0 = 4;
    localparam int bit_tp_off = 0;
    localparam int bit_acbg = 1;
    localparam int bit_adc_en = 2;
    localparam int bit_ac_off = 3;
    localparam logic [2:0] code_idle = 3'h0;
    localparam logic [2:0] code_adcnr = 3'h1;
    localparam logic [2:0] code_pdown = 3'h2;
    localparam logic [2:0] code_psave = 3'h3;
    localparam logic [2:0] code_stby = 3'h6;
    localparam logic [2:0] code_xstby = 3'h7;
    localparam int clk_mhz = 25;
    localparam int stby_wake_cycles = 6;
    localparam int irq_hold_cycles = 4;
    localparam int level_hold_ns = 200;
    localparam int level_hold_cycles = (level_hold_ns * clk_mhz + 999) / 1000;
    typedef enum logic [2:0] {st_run, st_sleep, st_startup, st_hold} state_type;
endpackage

// >>> verilog/sleep_mode_controller.sv
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module sleep_mode_controller #(
    parameter int startup_cycles = 16 // start-up delay chosen by clock fuses
) (
    input wire logic clk, // 25 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [3:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    input wire logic wb_we_i, // write enable
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    input wire logic sleep_instr, // cpu executes a sleep instruction, pulse
    input wire logic crystal_sel, // clock source fuses select crystal
    input wire logic brownout_fuse_on, // brown-out detector fuse
    input wire logic debug_fuse_on, // on-chip debug fuse
    input wire logic test_port_fuse_on, // test port fuse programmed
    input wire logic wdt_enabled, // watchdog enabled
    input wire logic gie, // global irq enable from cpu flags word
    input wire logic slow_timer_external_clock, // slow timer runs on own clock
    input wire logic [1:0] slow_timer_irq_en, // overflow, compare enables
    input wire logic [1:0] slow_timer_evt, // overflow, compare events
    input wire logic ext_irq_line_0, // external line 0, level
    input wire logic ext_irq_line_1, // external line 1, level
    input wire logic ext_irq2_evt, // external line 2 edge event
    input wire logic [1:0] ext_level_en, // line 0/1 level irq enabled
    input wire logic addr_match_irq, // serial-bus address match
    input wire logic other_irq, // any other enabled interrupt
    input wire logic reset_wake, // external/watchdog/brown-out reset request
    input wire logic tap_shifting, // test port shifting data
    output logic cpu_clk_en, // cpu and flash clock gate
    output logic io_clk_en, // io clock gate
    output logic adc_clk_en, // adc clock gate
    output logic asy_clk_en, // slow timer clock gate
    output logic osc_en, // main oscillator enable
    output logic cpu_halt, // cpu held
    output logic irq_service, // wake by interrupt, pulse
    output logic comparator_en, // analog comparator enable
    output logic adc_en, // adc enable
    output logic vref_en, // internal reference enable
    output logic bod_en, // brown-out detector enable
    output logic wdt_run, // watchdog running
    output logic input_buf_en, // general digital input buffers
    output logic wake_buf_en, // wake-detect input buffers
    output logic slow_timer_undef, // timer contents undefined flag
    output logic adc_extended, // next conversion extended
    output logic test_port_en, // boundary-scan enabled
    output logic tdo_oe // tdo drive enable
);
    import sleep_pkg::*;

    logic [7:0] control_r;
    logic [7:0] misc_r;
    logic [2:0] mode_r;
    state_type state_r;
    logic [15:0] cnt_r;
    logic irq_wake_r;
    logic [7:0] lvl_cnt_r;
    logic undef_r;
    logic ext_r;
    logic adc_prev_r;
    logic [2:0] code;
    logic enter;
    logic wake_irq;
    logic level_ok;
    logic asleep;
    logic wb_hit;

    // every check below runs on the system clock and rests while reset is low
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // mode code assembled from scattered bits
    assign code = {control_r[bit_sm2], control_r[bit_sm1], control_r[bit_sm0]};
    // reserved codes and a clear enable bit leave everything untouched
    assign enter = sleep_instr && state_r == st_run && control_r[bit_se]
        && (code != 3'h4) && (code != 3'h5)
        && !((code == code_stby || code == code_xstby) && !crystal_sel);
    assign asleep = state_r == st_sleep;
    assign wb_hit = wb_cyc_i && wb_stb_i;

    // bus slave: single-cycle ack, released the cycle after
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit && !wb_ack_o;
        end
    end

    // register writes on the acked edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            control_r <= control_reset;
            misc_r <= misc_reset;
        end else if (wb_hit && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == adr_control) begin
                control_r <= wb_dat_i[7:0];
            end else if (wb_adr_i == adr_misc) begin
                misc_r <= wb_dat_i[7:0];
            end
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        wb_dat_o = 32'h0;
        unique case (wb_adr_i)
            adr_control: wb_dat_o = {24'h0, control_r};
            adr_status: wb_dat_o = {24'h0, 2'h0, adc_extended, undef_r, mode_r, asleep};
            adr_misc: wb_dat_o = {24'h0, misc_r};
            default: wb_dat_o = 32'h0;
        endcase
    end

    // level wake needs the level held a minimum time; counted here, level_hold_ns rounded up to cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lvl_cnt_r <= 8'h0;
        end else if (asleep && ((ext_level_en[0] && !ext_irq_line_0) || (ext_level_en[1] && !ext_irq_line_1))) begin
            if (lvl_cnt_r != 8'(level_hold_cycles)) begin
                lvl_cnt_r <= lvl_cnt_r + 8'h1;
            end
        end else begin
            lvl_cnt_r <= 8'h0;
        end
    end
    assign level_ok = lvl_cnt_r == 8'(level_hold_cycles);

    // wake qualification per mode
    always_comb begin
        wake_irq = addr_match_irq || ext_irq2_evt || level_ok;
        unique case (mode_r)
            code_idle: wake_irq = 1'b1 && (wake_irq || other_irq || (|slow_timer_evt));
            code_adcnr: wake_irq = wake_irq || (|(slow_timer_evt & slow_timer_irq_en)) || other_irq;
            code_psave, code_xstby: wake_irq = wake_irq
                || (gie && slow_timer_external_clock && |(slow_timer_evt & slow_timer_irq_en));
            default: wake_irq = wake_irq;
        endcase
    end

    // sleep sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= st_run;
            mode_r <= code_idle;
            cnt_r <= 16'h0;
            irq_wake_r <= 1'b0;
        end else begin
            unique case (state_r)
                st_run: if (enter) begin
                    state_r <= st_sleep;
                    mode_r <= code;
                end
                st_sleep: if (reset_wake || wake_irq) begin
                    irq_wake_r <= !reset_wake;
                    state_r <= st_startup;
                    // oscillator kept running means a short restart
                    if (mode_r == code_stby || mode_r == code_xstby) begin
                        cnt_r <= 16'(stby_wake_cycles - 1);
                    end else if (mode_r == code_idle || mode_r == code_adcnr) begin
                        cnt_r <= 16'h0;
                    end else begin
                        cnt_r <= 16'(startup_cycles - 1);
                    end
                end
                st_startup: if (cnt_r != 16'h0) begin
                    cnt_r <= cnt_r - 16'h1;
                end else if (irq_wake_r) begin
                    state_r <= st_hold;
                    cnt_r <= 16'(irq_hold_cycles - 1);
                end else begin
                    state_r <= st_run;
                end
                st_hold: if (cnt_r != 16'h0) begin
                    cnt_r <= cnt_r - 16'h1;
                end else begin
                    state_r <= st_run;
                    irq_wake_r <= 1'b0;
                end
                default: state_r <= st_run;
            endcase
        end
    end

    // irq service pulse as cpu is released
    assign irq_service = state_r == st_hold && cnt_r == 16'h0;
    assign cpu_halt = state_r != st_run;

    // clock gating per mode; deep modes only leave async logic alive
    always_comb begin
        cpu_clk_en = 1'b1;
        io_clk_en = 1'b1;
        adc_clk_en = 1'b1;
        asy_clk_en = 1'b1;
        osc_en = 1'b1;
        if (asleep) begin
            cpu_clk_en = 1'b0;
            unique case (mode_r)
                code_idle: begin
                end
                code_adcnr: io_clk_en = 1'b0;
                code_pdown, code_stby: begin
                    io_clk_en = 1'b0;
                    adc_clk_en = 1'b0;
                    asy_clk_en = 1'b0;
                    osc_en = mode_r == code_stby || debug_fuse_on;
                end
                default: begin
                    io_clk_en = 1'b0;
                    adc_clk_en = 1'b0;
                    asy_clk_en = slow_timer_external_clock;
                    osc_en = mode_r == code_xstby || debug_fuse_on;
                end
            endcase
        end
    end

    // analog side effects
    assign adc_en = misc_r[bit_adc_en];
    assign comparator_en = !misc_r[bit_ac_off]
        && !(asleep && mode_r != code_idle && mode_r != code_adcnr);
    assign bod_en = brownout_fuse_on;
    // reference held for comparator while its bandgap bit is set and its off bit clear, even in deep sleep
    assign vref_en = brownout_fuse_on || adc_en || (misc_r[bit_acbg] && !misc_r[bit_ac_off]);
    assign wdt_run = wdt_enabled;
    assign input_buf_en = io_clk_en || adc_clk_en;
    assign wake_buf_en = 1'b1;
    assign test_port_en = test_port_fuse_on && !misc_r[bit_tp_off];
    assign tdo_oe = test_port_en && tap_shifting;
    assign slow_timer_undef = undef_r;
    assign adc_extended = ext_r;

    // timer contents flagged undefined after synchronous-clock power-save
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            undef_r <= 1'b0;
        end else if (asleep && mode_r == code_psave && !slow_timer_external_clock) begin
            undef_r <= 1'b1;
        end else if (enter) begin
            undef_r <= 1'b0;
        end
    end

    // adc off then on: next conversion extended, cleared when sleep is entered with the adc on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adc_prev_r <= 1'b0;
            ext_r <= 1'b1;
        end else begin
            adc_prev_r <= adc_en;
            if (adc_en && !adc_prev_r) begin
                ext_r <= 1'b1;
            end else if (adc_en && enter) begin
                ext_r <= 1'b0;
            end
        end
    end

    property p_no_enter_without_se;
        @(posedge clk) disable iff (!nrst) (state_r == st_run && !control_r[bit_se])
            |=> state_r != st_sleep;
    endproperty
    a_no_enter_without_se: assert property (p_no_enter_without_se) else $error("sleep without enable");
    property p_reserved;
        @(posedge clk) disable iff (!nrst) (sleep_instr && (code == 3'h4 || code == 3'h5))
            |=> !asleep;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code slept");
    property p_pdown_clocks;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_pdown)
            |-> !io_clk_en && !asy_clk_en && !cpu_clk_en;
    endproperty
    a_pdown_clocks: assert property (p_pdown_clocks) else $error("power-down clock running");
    property p_osc_pd;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_pdown && !debug_fuse_on)
            |-> !osc_en;
    endproperty
    a_osc_pd: assert property (p_osc_pd) else $error("oscillator on in power-down");
    property p_stby_wake;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_stby && reset_wake)
            |=> cpu_halt [*6] ##1 !cpu_halt;
    endproperty
    a_stby_wake: assert property (p_stby_wake) else $error("standby wake not six cycles");
    property p_hold4;
        @(posedge clk) disable iff (!nrst) $rose(state_r == st_hold)
            |-> cpu_halt [*4] ##1 !cpu_halt;
    endproperty
    a_hold4: assert property (p_hold4) else $error("irq hold not four cycles");
    property p_psave_asy;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_psave) |-> asy_clk_en == slow_timer_external_clock;
    endproperty
    a_psave_asy: assert property (p_psave_asy) else $error("slow timer clock wrong");
    property p_ac_off;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_pdown) |-> !comparator_en;
    endproperty
    a_ac_off: assert property (p_ac_off) else $error("comparator on in deep sleep");
    property p_tdo;
        @(posedge clk) disable iff (!nrst) !tap_shifting |-> !tdo_oe;
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo driven while idle");
    property p_psave_nowake;
        @(posedge clk) disable iff (!nrst) (asleep && mode_r == code_psave && !gie && !reset_wake && !addr_match_irq
            && !ext_irq2_evt && !level_ok) |=> asleep;
    endproperty
    a_psave_nowake: assert property (p_psave_nowake) else $error("power-save woke without gie");
    // clock tree per light and standby mode
    property p_idle_clk;
        asleep && mode_r == code_idle
            |-> !cpu_clk_en && io_clk_en && adc_clk_en && asy_clk_en;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("idle gating wrong");
    property p_adcnr_clk;
        asleep && mode_r == code_adcnr
            |-> !cpu_clk_en && !io_clk_en && adc_clk_en && asy_clk_en;
    endproperty
    a_adcnr_clk: assert property (p_adcnr_clk) else $error("noise mode gating wrong");
    property p_stby_osc;
        asleep && mode_r == code_stby
            |-> osc_en && !io_clk_en && !adc_clk_en && !asy_clk_en;
    endproperty
    a_stby_osc: assert property (p_stby_osc) else $error("standby gating wrong");
    property p_xstby_osc;
        asleep && mode_r == code_xstby
            |-> osc_en && !adc_clk_en && asy_clk_en == slow_timer_external_clock;
    endproperty
    a_xstby_osc: assert property (p_xstby_osc) else $error("ext standby gating wrong");
    // comparator is forced off in every deeper mode, whatever its own setting
    property p_ac_deep;
        asleep && mode_r != code_idle && mode_r != code_adcnr
            |-> !comparator_en;
    endproperty
    a_ac_deep: assert property (p_ac_deep) else $error("comparator on in sleep");
    // side effects that must hold through any sleep
    property p_inbuf;
        !io_clk_en && !adc_clk_en
            |-> !input_buf_en && wake_buf_en;
    endproperty
    a_inbuf: assert property (p_inbuf) else $error("input buffers wrong");
    property p_keep_on;
        asleep
            |-> bod_en == brownout_fuse_on && wdt_run == wdt_enabled;
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("detector or watchdog stopped");
    property p_adc_ext;
        $rose(adc_en)
            |=> adc_extended;
    endproperty
    a_adc_ext: assert property (p_adc_ext) else $error("adc restart not extended");
    property p_tp_off;
        misc_r[bit_tp_off]
            |-> !test_port_en && !tdo_oe;
    endproperty
    a_tp_off: assert property (p_tp_off) else $error("test port not off");
    // wake path: synchronous timer loses its contents, deep wake loads the fuse delay
    property p_undef;
        asleep && mode_r == code_psave && !slow_timer_external_clock
            |=> slow_timer_undef;
    endproperty
    a_undef: assert property (p_undef) else $error("timer not flagged");
    property p_pd_startup;
        asleep && mode_r == code_pdown && reset_wake
            |=> state_r == st_startup && cnt_r == 16'(startup_cycles - 1);
    endproperty
    a_pd_startup: assert property (p_pd_startup) else $error("start-up delay wrong");
    // scenarios worth seeing reached
    c_pdown: cover property (@(posedge clk) disable iff (!nrst) asleep && mode_r == code_pdown);
    c_xstby: cover property (@(posedge clk) disable iff (!nrst) asleep && mode_r == code_xstby);
    c_irq: cover property (@(posedge clk) disable iff (!nrst) irq_service);
    c_stby_wake: cover property (asleep && mode_r == code_stby && reset_wake);
    c_level_wake: cover property (asleep && level_ok);
endmodule

// >>> tb/cpu_partner.sv
`timescale 1ns/100ps
// far side: cpu core and wake sources; everything changes just after a rising edge
module cpu_partner (
    input wire logic clk, // system clock
    output logic sleep_instr, // sleep instruction pulse
    output logic reset_wake, // reset request
    output logic other_irq, // interrupt outside the deep-sleep wake set
    output logic ext_irq2_evt, // line 2 event
    output logic addr_match_irq, // serial-bus address match
    output logic [1:0] slow_timer_evt, // overflow, compare events
    output logic ext_irq_line_0, // level line 0, idles high
    output logic ext_irq_line_1 // level line 1, idles high
);
    // all sources quiet, level lines released high
    initial begin
        {sleep_instr, reset_wake, other_irq, ext_irq2_evt, addr_match_irq, slow_timer_evt} = '0;
        {ext_irq_line_0, ext_irq_line_1} = 2'h3;
    end
    // one-cycle pulse: 0 sleep, 1 reset, 2 other, 3 line 2, 4 match, 5 overflow, 6 compare
    task automatic pulse(input int src);
        @(posedge clk);
        {sleep_instr, reset_wake, other_irq, ext_irq2_evt, addr_match_irq, slow_timer_evt} <= 7'h40 >> src;
        @(posedge clk);
        {sleep_instr, reset_wake, other_irq, ext_irq2_evt, addr_match_irq, slow_timer_evt} <= '0;
    endtask
    // a level source keeps its line low for a chosen time before letting go
    task automatic hold_low(input int line, input int n);
        @(posedge clk);
        {ext_irq_line_1, ext_irq_line_0} <= (line == 0) ? 2'h2 : 2'h1;
        repeat (n) @(posedge clk);
        {ext_irq_line_1, ext_irq_line_0} <= 2'h3;
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import sleep_pkg::*;
    localparam int su = 2; // short start-up keeps the run brief
    logic clk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sleep_instr, crystal_sel, brownout_fuse_on;
    logic debug_fuse_on, test_port_fuse_on, wdt_enabled, gie, slow_timer_external_clock, ext_irq_line_0;
    logic ext_irq_line_1, ext_irq2_evt, addr_match_irq, other_irq, reset_wake, tap_shifting, cpu_clk_en;
    logic io_clk_en, adc_clk_en, asy_clk_en, osc_en, cpu_halt, irq_service, comparator_en, adc_en, vref_en;
    logic bod_en, wdt_run, input_buf_en, wake_buf_en, slow_timer_undef, adc_extended, test_port_en, tdo_oe;
    logic [3:0] wb_adr_i, wb_sel_i, sel;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [1:0] slow_timer_irq_en, slow_timer_evt, ext_level_en;
    logic [2:0] codes[6] = '{code_idle, code_adcnr, code_pdown, code_psave, code_stby, code_xstby};
    logic [5:0] gates[6] = '{6'h1f, 6'h0f, 6'h00, 6'h04, 6'h02, 6'h06}; // cpu io adc asy osc inbuf
    int dur[6] = '{1, 1, su, su, 6, 6};
    logic [7:0] refused[4] = '{8'h20, 8'hc0, 8'hd0, 8'he0};
    int err_count = 0;
    int checks = 0;

    sleep_mode_controller #(.startup_cycles(su)) DUT (.clk, .nrst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_instr, .crystal_sel, .brownout_fuse_on, .debug_fuse_on,
        .test_port_fuse_on, .wdt_enabled, .gie, .slow_timer_external_clock, .slow_timer_irq_en, .slow_timer_evt,
        .ext_irq_line_0, .ext_irq_line_1, .ext_irq2_evt, .ext_level_en, .addr_match_irq, .other_irq, .reset_wake,
        .tap_shifting, .cpu_clk_en, .io_clk_en, .adc_clk_en, .asy_clk_en, .osc_en, .cpu_halt, .irq_service,
        .comparator_en, .adc_en, .vref_en, .bod_en, .wdt_run, .input_buf_en, .wake_buf_en, .slow_timer_undef,
        .adc_extended, .test_port_en, .tdo_oe);
    cpu_partner P (.clk, .sleep_instr, .reset_wake, .other_irq, .ext_irq2_evt, .addr_match_irq, .slow_timer_evt,
        .ext_irq_line_0, .ext_irq_line_1);

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic single wishbone cycle; the answer is taken at the edge that shows ack
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, sel};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        if (n >= 20) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    // let the edge's updates land before looking
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic go_sleep(input logic [2:0] c);
        wr(adr_control, {24'h0, c[2], 1'b1, c[1:0], 4'h0});
        P.pulse(0);
        settle();
    endtask
    // counts halted cycles after the wake source is seen, and service pulses
    task automatic wake(input int src, input int exp_n, input int exp_s);
        int n;
        int s;
        n = 0;
        s = 0;
        P.pulse(src);
        do begin
            settle();
            n++;
            s += (irq_service === 1'b1);
        end while (cpu_halt === 1'b1 && n < 100);
        check("wake cycles", n, exp_n);
        check("irq service", s, exp_s);
    endtask

    // main sequence: reset, registers, every mode, wake qualification, side outputs
    initial begin
        {nrst, wb_we_i, wb_cyc_i, wb_stb_i, gie, tap_shifting, debug_fuse_on} = '0;
        {crystal_sel, brownout_fuse_on, test_port_fuse_on, wdt_enabled, slow_timer_external_clock} = 5'h1f;
        {wb_adr_i, wb_sel_i, wb_dat_i, sel} = 44'h1;
        {slow_timer_irq_en, ext_level_en} = 4'h3;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdc(adr_control, 32'h0, "control reset");
        rdc(adr_misc, 32'h0, "misc reset");
        rdc(adr_status, 32'h20, "status reset");
        wr(4'hc, 32'hff);
        rdc(4'hc, 32'h0, "unmapped");
        rdc(adr_control, 32'h0, "control kept");
        sel = 4'h0;
        wr(adr_control, 32'hff);
        sel = 4'h1;
        rdc(adr_control, 32'h0, "lane off");
        for (int j = 0; j < 4; j++) begin
            crystal_sel <= (j != 3);
            wr(adr_control, {24'h0, refused[j]});
            rdc(adr_control, {24'h0, refused[j]}, "control");
            P.pulse(0);
            settle();
            check("refused", {cpu_halt, cpu_clk_en, io_clk_en, osc_en}, 4'h7);
        end
        crystal_sel <= 1'b1;
        wr(adr_misc, 32'h4);
        for (int i = 0; i < 6; i++) begin
            go_sleep(codes[i]);
            check("gates", {cpu_clk_en, io_clk_en, adc_clk_en, asy_clk_en, osc_en, input_buf_en}, gates[i]);
            check("comparator", comparator_en, i < 2);
            check("kept on", {bod_en, wdt_run, adc_en, vref_en, wake_buf_en}, 5'h1f);
            rdc(adr_status, {28'h0, codes[i], 1'b1}, "status mode");
            wake(1, dur[i], 0);
        end
        // deep sleep ignores sources outside its wake set, and short level pulses
        {gie, ext_level_en} <= 3'h5;
        go_sleep(code_pdown);
        P.pulse(2);
        P.pulse(5);
        P.hold_low(1, 8);
        P.hold_low(0, 3);
        settle();
        check("pdown held", cpu_halt, 1'b1);
        ext_level_en <= 2'h3;
        P.hold_low(1, 8);
        repeat (12) settle();
        check("level wake", cpu_halt, 1'b0);
        go_sleep(code_pdown);
        wake(3, su + 4, 1);
        go_sleep(code_pdown);
        wake(4, su + 4, 1);
        // slow timer wakes only with both enables
        slow_timer_irq_en <= 2'h0;
        go_sleep(code_psave);
        P.pulse(5);
        {slow_timer_irq_en, gie} <= 3'h6;
        P.pulse(6);
        settle();
        check("psave held", cpu_halt, 1'b1);
        gie <= 1'b1;
        wake(6, su + 4, 1);
        slow_timer_external_clock <= 1'b0;
        go_sleep(code_psave);
        wake(1, su, 0);
        rdc(adr_status, 32'h16, "timer undefined");
        {debug_fuse_on, wdt_enabled} <= 2'h2;
        go_sleep(code_pdown);
        check("debug osc", {osc_en, wdt_run}, 2'h2);
        wake(1, su, 0);
        // test port and reference enables
        tap_shifting <= 1'b1;
        settle();
        check("tap", {test_port_en, tdo_oe}, 2'h3);
        tap_shifting <= 1'b0;
        settle();
        check("tdo float", {test_port_en, tdo_oe}, 2'h2);
        wr(adr_misc, 32'h1);
        settle();
        check("tap off", test_port_en, 1'b0);
        {brownout_fuse_on, test_port_fuse_on} <= 2'h0;
        wr(adr_misc, 32'h0);
        settle();
        check("vref off", {vref_en, test_port_en}, 2'h0);
        wr(adr_misc, 32'h2);
        settle();
        check("vref comparator", vref_en, 1'b1);
        stop_test();
    end
endmodule
